// File: hdl/gio_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1 - Low reset pin resets whole system; input
// RL2 - Pin reset clears RTC, keeps backup RAM
// RL3 - Event inputs ignored until enabled
// RL4 - Enabled events wake receiver, deliver aiding
// RL5 - Power control: event level sets receiver state
// RL6 - Outside low power, event low forces off
// RL7 - Time aiding: capture time on pulse edge
// RL8 - Frequency aiding: max 500 kHz, 50 ns
// RL9 - Strap open UART/DDC, low SPI, exclusive
// RL10 - Serial pins shared per interface strap
// RL11 - Time pulse defaults to one per second
// RL12 - Host keeps boot strap high during reset
// RL13 - Second pulse pin not held low startup
// RL14 - Low power: amplifier enable follows receiver
// RL15 - Transmit pin may show transmit pending
// RL16 - Pending: byte threshold, polarity, default off
// RL17 - Pins pass two flip-flops before use
module gio_top #(
	parameter logic [gio_pkg::TP_W-1:0] TP_PERIOD_DEF = gio_pkg::TP_PERIOD_CYC,
	parameter logic [gio_pkg::TP_W-1:0] TP_WIDTH_DEF  = gio_pkg::TP_WIDTH_CYC
) (
	input  wire logic                          MCLK,
	input  wire logic                          RESET,
	input  wire logic                          RESET_N_PIN,
	input  wire logic                          EXT_EVENT_IN_FIRST,
	input  wire logic                          EXT_EVENT_IN_SECOND,
	input  wire logic                          IFACE_SEL_PIN,
	input  wire logic                          BOOT_MODE_STRAP_LOW_IN,
	output var  logic                          SECOND_PULSE_PIN_OUT,
	output var  logic                          SECOND_PULSE_PIN_OE,
	input  wire logic                          RXD_PIN,
	output var  logic                          TXD_PIN,
	input  wire logic                          SDA_PIN_IN,
	output var  logic                          SDA_PIN_OUT,
	output var  logic                          SDA_PIN_OE,
	input  wire logic                          SCL_PIN,
	input  wire gio_pkg::gio_cfg_t             CFG,
	input  wire logic                          PSM_CYCLE_ON,
	input  wire logic [gio_pkg::QUEUE_W-1:0]   TX_QUEUE_BYTES,
	input  wire gio_pkg::gio_ser_in_t          SER_IN,
	output var  gio_pkg::gio_ser_out_t         SER_OUT,
	input  wire logic                          BKP_WE,
	input  wire logic [gio_pkg::BKP_AW-1:0]    BKP_ADDR,
	input  wire logic [gio_pkg::BKP_DW-1:0]    BKP_WDATA,
	output var  logic [gio_pkg::BKP_DW-1:0]    BKP_RDATA,
	output var  logic                          SYS_RESET,
	output var  logic                          SPI_MODE,
	output var  logic                          SERVICE_BOOT,
	output var  logic                          RX_ON,
	output var  logic                          WAKE,
	output var  logic                          ANTENNA_AMP_ON,
	output var  logic                          TIMEPULSE,
	output var  logic [gio_pkg::N_EVENT-1:0]   TIME_SYNC,
	output var  logic [gio_pkg::RTC_W-1:0]     TIME_CAPT_FIRST,
	output var  logic [gio_pkg::RTC_W-1:0]     TIME_CAPT_SECOND,
	output var  logic [gio_pkg::RTC_W-1:0]     RTC_TIME,
	output var  logic [gio_pkg::AID_W-1:0]     AID_PERIOD,
	output var  logic                          AID_EDGE
);

	logic [gio_pkg::N_PINS-1:0]  pins_raw;
	logic [gio_pkg::N_PINS-1:0]  pins_s;
	logic [gio_pkg::N_EVENT-1:0] ev_s;
	logic                        hw_rst;

	assign pins_raw = {SCL_PIN, SDA_PIN_IN, RXD_PIN, BOOT_MODE_STRAP_LOW_IN, IFACE_SEL_PIN,
	                   EXT_EVENT_IN_SECOND, EXT_EVENT_IN_FIRST, RESET_N_PIN};

	// Only the power-on reset presets these high, so a pin reset cannot lose a strap edge
	gio_sync #(
		.W       (gio_pkg::N_PINS),
		.RST_VAL (gio_pkg::PIN_IDLE)
	) u_sync (
		.clk  (MCLK),
		.rst  (RESET),
		.din  (pins_raw),
		.dout (pins_s)
	); // [RL17]

	assign ev_s   = pins_s[gio_pkg::PIN_EV_LO +: gio_pkg::N_EVENT];
	assign hw_rst = RESET | ~pins_s[gio_pkg::PIN_RESET_N]; // [RL1]

	gio_pkg::gio_state_t                 st_q, st_d;
	logic                                spi_q, spi_d;
	logic                                boot_q, boot_d;
	logic                                sysrst_q, sysrst_d;
	logic [gio_pkg::N_EVENT-1:0]         ev_q, ev_d;
	logic [gio_pkg::N_EVENT-1:0]         tsync_q, tsync_d;
	logic [gio_pkg::RTC_W-1:0]           rtc_q, rtc_d;
	logic [gio_pkg::RTC_W-1:0]           capt_q [gio_pkg::N_EVENT];
	logic [gio_pkg::RTC_W-1:0]           capt_d [gio_pkg::N_EVENT];
	logic [gio_pkg::AID_W-1:0]           per_cnt_q, per_cnt_d;
	logic [gio_pkg::AID_W-1:0]           aid_per_q, aid_per_d;
	logic                                aid_edge_q, aid_edge_d;
	logic                                rx_on_q, rx_on_d;
	logic                                wake_q, wake_d;
	logic                                amp_q, amp_d;
	logic [gio_pkg::TP_W-1:0]            tp_cnt_q, tp_cnt_d;
	logic                                tp_q, tp_d;
	logic                                tp2_out_q, tp2_out_d;
	logic                                tp2_oe_q, tp2_oe_d;
	logic                                txd_q, txd_d;
	logic                                sda_oe_q, sda_oe_d;
	gio_pkg::gio_ser_out_t               ser_q, ser_d;

	logic                                run;
	logic [gio_pkg::N_EVENT-1:0]         ev_en;
	logic [gio_pkg::N_EVENT-1:0]         rise;
	logic [gio_pkg::TP_W-1:0]            tp_per;
	logic [gio_pkg::TP_W-1:0]            tp_wid;
	logic                                txp_act;
	logic                                rxd_s, sda_s, scl_s;

	always_comb begin
		run     = (st_q == gio_pkg::ST_RUN);
		ev_en   = CFG.event_en & {gio_pkg::N_EVENT{run}}; // [RL3]
		rise    = ev_s & ~ev_q & ev_en;
		rxd_s   = pins_s[gio_pkg::PIN_RXD];
		sda_s   = pins_s[gio_pkg::PIN_SDA];
		scl_s   = pins_s[gio_pkg::PIN_SCL];
		tp_per  = CFG.tp_custom ? CFG.tp_period : TP_PERIOD_DEF; // [RL11]
		tp_wid  = CFG.tp_custom ? CFG.tp_width : TP_WIDTH_DEF;
		txp_act = run & CFG.txp_en & (TX_QUEUE_BYTES != '0) & (TX_QUEUE_BYTES >= CFG.txp_thresh); // [RL16]

		st_d     = st_q;
		spi_d    = spi_q;
		boot_d   = boot_q;
		sysrst_d = 1'b0;
		case (st_q)
			gio_pkg::ST_HOLD: begin
				st_d = gio_pkg::ST_CAPTURE;
			end
			gio_pkg::ST_CAPTURE: begin
				// Straps are caught once, after reset has gone away
				spi_d  = ~pins_s[gio_pkg::PIN_DSEL]; // [RL9]
				boot_d = ~pins_s[gio_pkg::PIN_BOOT]; // [RL12]
				st_d   = gio_pkg::ST_RUN;
			end
			gio_pkg::ST_RUN: begin
				st_d = gio_pkg::ST_RUN;
			end
			default: begin
				st_d = gio_pkg::ST_HOLD;
			end
		endcase

		ev_d = ev_s;
		rtc_d = rtc_q + 1'b1;
		tsync_d = '0;
		for (int i = 0; i < gio_pkg::N_EVENT; i++) begin
			capt_d[i] = capt_q[i];
			if (CFG.time_aid_en & rise[i]) begin
				capt_d[i]  = rtc_q; // [RL7]
				tsync_d[i] = 1'b1;
			end
		end

		// Period is measured in clock cycles; a 50 ns phase is one cycle, the floor of this clock
		aid_edge_d = 1'b0;
		aid_per_d  = aid_per_q;
		per_cnt_d  = per_cnt_q;
		if (ev_en[0] & CFG.freq_aid_en) begin
			if (rise[0]) begin
				aid_per_d  = per_cnt_q; // [RL8]
				aid_edge_d = 1'b1;
				per_cnt_d  = gio_pkg::AID_CNT_ONE;
			end else if (per_cnt_q != '1) begin
				per_cnt_d = per_cnt_q + 1'b1;
			end
		end else begin
			per_cnt_d = gio_pkg::AID_RST;
		end

		wake_d = CFG.psm_active & CFG.wake_en & (|rise); // [RL4]
		if (ev_en[0] & CFG.pwr_ctrl_en) begin
			rx_on_d = ev_s[0]; // [RL5] [RL6]
		end else begin
			rx_on_d = CFG.psm_active ? PSM_CYCLE_ON : 1'b1;
		end
		amp_d = CFG.psm_active ? rx_on_d : 1'b1; // [RL14]

		if (tp_cnt_q + 1'b1 >= tp_per) begin
			tp_cnt_d = gio_pkg::TP_CNT_RST;
		end else begin
			tp_cnt_d = tp_cnt_q + 1'b1;
		end
		tp_d = run & (tp_cnt_d < tp_wid); // [RL11]
		// Pin stays released until enabled, so the strap reads clean at start-up
		tp2_oe_d  = run & CFG.tp2_en; // [RL13]
		tp2_out_d = tp_d;

		// Both interfaces never see the pins at once
		if (spi_q) begin
			txd_d        = SER_IN.spi_miso; // [RL10]
			sda_oe_d     = 1'b0;
			ser_d        = '{uart_rx: 1'b1, ddc_scl: 1'b1, ddc_sda: 1'b1,
			                 spi_mosi: rxd_s, spi_cs_n: sda_s, spi_clk: scl_s}; // [RL9]
		end else begin
			txd_d        = CFG.txp_map ? (txp_act ~^ CFG.txp_pol) : SER_IN.uart_tx; // [RL15]
			sda_oe_d     = SER_IN.ddc_sda_low;
			ser_d        = '{uart_rx: rxd_s, ddc_scl: scl_s, ddc_sda: sda_s,
			                 spi_mosi: 1'b0, spi_cs_n: 1'b1, spi_clk: 1'b0}; // [RL10]
		end
		if (!run) begin
			txd_d    = 1'b1;
			sda_oe_d = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (hw_rst) begin
			st_q       <= gio_pkg::ST_HOLD;
			spi_q      <= 1'b0;
			boot_q     <= 1'b0;
			sysrst_q   <= 1'b1;
			ev_q       <= '1;
			tsync_q    <= '0;
			rtc_q      <= gio_pkg::RTC_RST; // [RL2]
			capt_q[0]  <= gio_pkg::RTC_RST;
			capt_q[1]  <= gio_pkg::RTC_RST;
			per_cnt_q  <= gio_pkg::AID_RST;
			aid_per_q  <= gio_pkg::AID_RST;
			aid_edge_q <= 1'b0;
			rx_on_q    <= 1'b0;
			wake_q     <= 1'b0;
			amp_q      <= 1'b0;
			tp_cnt_q   <= gio_pkg::TP_CNT_RST;
			tp_q       <= 1'b0;
			tp2_out_q  <= 1'b0;
			tp2_oe_q   <= 1'b0;
			txd_q      <= 1'b1;
			sda_oe_q   <= 1'b0;
			ser_q      <= '{uart_rx: 1'b1, ddc_scl: 1'b1, ddc_sda: 1'b1,
			                spi_mosi: 1'b0, spi_cs_n: 1'b1, spi_clk: 1'b0};
		end else begin
			st_q       <= st_d;
			spi_q      <= spi_d;
			boot_q     <= boot_d;
			sysrst_q   <= sysrst_d;
			ev_q       <= ev_d;
			tsync_q    <= tsync_d;
			rtc_q      <= rtc_d;
			capt_q[0]  <= capt_d[0];
			capt_q[1]  <= capt_d[1];
			per_cnt_q  <= per_cnt_d;
			aid_per_q  <= aid_per_d;
			aid_edge_q <= aid_edge_d;
			rx_on_q    <= rx_on_d;
			wake_q     <= wake_d;
			amp_q      <= amp_d;
			tp_cnt_q   <= tp_cnt_d;
			tp_q       <= tp_d;
			tp2_out_q  <= tp2_out_d;
			tp2_oe_q   <= tp2_oe_d;
			txd_q      <= txd_d;
			sda_oe_q   <= sda_oe_d;
			ser_q      <= ser_d;
		end
	end

	// Backup RAM: only power-on reset blocks it, the reset pin leaves contents alone
	logic [gio_pkg::BKP_DW-1:0] bkp_q [gio_pkg::BKP_DEPTH];
	logic [gio_pkg::BKP_DW-1:0] bkp_d [gio_pkg::BKP_DEPTH];
	logic [gio_pkg::BKP_DW-1:0] bkp_rd_q, bkp_rd_d;

	always_comb begin
		for (int i = 0; i < gio_pkg::BKP_DEPTH; i++) begin
			bkp_d[i] = bkp_q[i];
		end
		if (BKP_WE) begin
			bkp_d[BKP_ADDR] = BKP_WDATA; // [RL2]
		end
		bkp_rd_d = bkp_q[BKP_ADDR];
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			bkp_rd_q <= gio_pkg::BKP_RD_RST;
		end else begin
			bkp_rd_q <= bkp_rd_d;
			for (int i = 0; i < gio_pkg::BKP_DEPTH; i++) begin
				bkp_q[i] <= bkp_d[i];
			end
		end
	end

	assign SYS_RESET            = sysrst_q;
	assign SPI_MODE             = spi_q;
	assign SERVICE_BOOT         = boot_q;
	assign RX_ON                = rx_on_q;
	assign WAKE                 = wake_q;
	assign ANTENNA_AMP_ON       = amp_q;
	assign TIMEPULSE            = tp_q;
	assign SECOND_PULSE_PIN_OUT = tp2_out_q;
	assign SECOND_PULSE_PIN_OE  = tp2_oe_q;
	assign TIME_SYNC            = tsync_q;
	assign TIME_CAPT_FIRST      = capt_q[0];
	assign TIME_CAPT_SECOND     = capt_q[1];
	assign RTC_TIME             = rtc_q;
	assign AID_PERIOD           = aid_per_q;
	assign AID_EDGE             = aid_edge_q;
	assign TXD_PIN              = txd_q;
	assign SDA_PIN_OUT          = 1'b0;
	assign SDA_PIN_OE           = sda_oe_q;
	assign SER_OUT              = ser_q;
	assign BKP_RDATA            = bkp_rd_q;

endmodule // gio_top
`default_nettype wire

// File: hdl/gio_pkg.sv
package gio_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ             = 20_000_000;
	localparam int unsigned TP_PERIOD_S        = 1;
	localparam int unsigned TP_PERIOD_CYC      = CLK_HZ * TP_PERIOD_S;
	localparam int unsigned TP_WIDTH_MS        = 100;
	localparam int unsigned TP_WIDTH_CYC       = (CLK_HZ / 1000) * TP_WIDTH_MS;
	localparam int unsigned AID_MAX_FREQ_KHZ   = 500;
	localparam int unsigned AID_MIN_PERIOD_CYC = (CLK_HZ + AID_MAX_FREQ_KHZ * 1000 - 1) / (AID_MAX_FREQ_KHZ * 1000);
	localparam int unsigned AID_MIN_PHASE_NS   = 50;
	localparam int unsigned AID_MIN_PHASE_CYC  = (AID_MIN_PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Widths
	localparam int unsigned RTC_W     = 32;
	localparam int unsigned TP_W      = 32;
	localparam int unsigned AID_W     = 16;
	localparam int unsigned QUEUE_W   = 16;
	localparam int unsigned BKP_AW    = 2;
	localparam int unsigned BKP_DEPTH = 4;
	localparam int unsigned BKP_DW    = 8;
	localparam int unsigned N_EVENT   = 2;

	// Pin positions in the synchroniser vector
	localparam int unsigned PIN_RESET_N = 0;
	localparam int unsigned PIN_EV_LO   = 1;
	localparam int unsigned PIN_DSEL    = 3;
	localparam int unsigned PIN_BOOT    = 4;
	localparam int unsigned PIN_RXD     = 5;
	localparam int unsigned PIN_SDA     = 6;
	localparam int unsigned PIN_SCL     = 7;
	localparam int unsigned N_PINS      = 8;

	// Reset values
	localparam logic [N_PINS-1:0] PIN_IDLE    = 8'hff;
	localparam logic [RTC_W-1:0]  RTC_RST     = 32'h0000_0000;
	localparam logic [TP_W-1:0]   TP_CNT_RST  = 32'h0000_0000;
	localparam logic [AID_W-1:0]  AID_RST     = 16'h0000;
	localparam logic [AID_W-1:0]  AID_CNT_ONE = 16'h0001;
	localparam logic [BKP_DW-1:0] BKP_RD_RST  = 8'h00;

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_CAPTURE,
		ST_RUN
	} gio_state_t;

	typedef struct packed {
		logic [N_EVENT-1:0] event_en;
		logic               wake_en;
		logic               pwr_ctrl_en;
		logic               time_aid_en;
		logic               freq_aid_en;
		logic               psm_active;
		logic               tp_custom;
		logic [TP_W-1:0]    tp_period;
		logic [TP_W-1:0]    tp_width;
		logic               tp2_en;
		logic               txp_en;
		logic               txp_map;
		logic               txp_pol;
		logic [QUEUE_W-1:0] txp_thresh;
	} gio_cfg_t;

	typedef struct packed {
		logic uart_tx;
		logic spi_miso;
		logic ddc_sda_low;
	} gio_ser_in_t;

	typedef struct packed {
		logic uart_rx;
		logic ddc_scl;
		logic ddc_sda;
		logic spi_mosi;
		logic spi_cs_n;
		logic spi_clk;
	} gio_ser_out_t;

endpackage

// File: hdl/gio_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gio_sync #(
	parameter int unsigned      W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				meta_d[i] = din[i];
				sync_d[i] = meta_q[i];
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q[i] <= RST_VAL[i];
					sync_q[i] <= RST_VAL[i];
				end else begin
					meta_q[i] <= meta_d[i];
					sync_q[i] <= sync_d[i];
				end
			end
		end
	endgenerate

	assign dout = sync_q;

endmodule // gio_sync
`default_nettype wire

// File: bench/gio_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module gio_top_chk (
	input wire logic                        MCLK,
	input wire logic                        RESET,
	input wire logic                        RESET_N_PIN,
	input wire logic                        EXT_EVENT_IN_FIRST,
	input wire gio_pkg::gio_cfg_t           CFG,
	input wire logic [gio_pkg::QUEUE_W-1:0] TX_QUEUE_BYTES,
	input wire gio_pkg::gio_ser_in_t        SER_IN,
	input wire gio_pkg::gio_ser_out_t       SER_OUT,
	input wire logic                        TXD_PIN,
	input wire logic                        SECOND_PULSE_PIN_OE,
	input wire logic                        SYS_RESET,
	input wire logic                        SPI_MODE,
	input wire logic                        RX_ON,
	input wire logic                        WAKE,
	input wire logic                        ANTENNA_AMP_ON,
	input wire logic [gio_pkg::N_EVENT-1:0] TIME_SYNC,
	input wire logic [gio_pkg::RTC_W-1:0]   TIME_CAPT_FIRST,
	input wire logic [gio_pkg::RTC_W-1:0]   RTC_TIME
);
	logic txp_hit;
	assign txp_hit = !SYS_RESET && !SPI_MODE && CFG.txp_map && CFG.txp_en && TX_QUEUE_BYTES != 16'h0
		&& TX_QUEUE_BYTES >= CFG.txp_thresh;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	// Five cycles covers the two sync stages plus the register
	sequence s_pin_low;
		!RESET_N_PIN [*5];
	endsequence
	sequence s_ovr_run;
		(!SYS_RESET && CFG.event_en[0] && CFG.pwr_ctrl_en) [*4];
	endsequence
	a_pin_reset: assert property (s_pin_low |-> SYS_RESET)
		else $error("pin reset not applied");
	a_rtc_clear: assert property (s_pin_low |-> RTC_TIME == 32'h0)
		else $error("clock time not cleared");
	a_event_off: assert property ((!CFG.event_en[0]) [*3] |-> !TIME_SYNC[0])
		else $error("disabled event acted");
	a_wake_pulse: assert property (WAKE |=> !WAKE)
		else $error("wake longer than one cycle");
	a_ovr_level: assert property (s_ovr_run |-> RX_ON == $past(EXT_EVENT_IN_FIRST, 3))
		else $error("receiver state not set by event level");
	a_time_capt: assert property (TIME_SYNC[0] |-> TIME_CAPT_FIRST == $past(RTC_TIME))
		else $error("time not captured at edge");
	a_iface_excl: assert property ($past(SPI_MODE) && SPI_MODE
		|-> SER_OUT.uart_rx && SER_OUT.ddc_scl && SER_OUT.ddc_sda)
		else $error("serial side active in SPI mode");
	a_miso_share: assert property (SPI_MODE && !SYS_RESET ##1 !SYS_RESET
		|-> TXD_PIN == $past(SER_IN.spi_miso))
		else $error("transmit pin not carrying MISO");
	a_tp2_quiet: assert property (!CFG.tp2_en |=> !SECOND_PULSE_PIN_OE)
		else $error("second pulse driven while off");
	a_amp_full: assert property ((!SYS_RESET && !CFG.psm_active) [*3] |-> ANTENNA_AMP_ON)
		else $error("amplifier off outside low power");
	a_txp_level: assert property (!SYS_RESET && $past(txp_hit) |-> TXD_PIN == $past(CFG.txp_pol))
		else $error("pending level wrong");
endmodule // gio_top_chk
`default_nettype wire

// File: bench/gio_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module gio_host_mdl (
	input wire logic       clk,
	input wire logic       rst_req,
	input wire logic       iface_uart,
	input wire logic [1:0] ev_lvl,
	input wire logic [7:0] aid_half,
	input wire logic       tp2_oe,
	input wire logic       tp2_out,
	output var logic       reset_n_pin,
	output var logic [1:0] ev_pin,
	output var logic       iface_pin,
	output var logic       tp2_wire
);
	logic [7:0] aid_cnt;
	// Board only pulls up, never low in reset or start-up
	assign tp2_wire = tp2_oe ? tp2_out : 1'h1;
	initial begin
		reset_n_pin = 1'h1;
		ev_pin = 2'h3;
		iface_pin = 1'h1;
		aid_cnt = 8'h00;
	end
	always @(posedge clk) begin
		reset_n_pin <= !rst_req;
		iface_pin <= iface_uart;
		ev_pin[1] <= ev_lvl[1];
		if (aid_half == 8'h00) begin
			aid_cnt <= 8'h00;
			ev_pin[0] <= ev_lvl[0];
		end else if (aid_cnt == aid_half - 8'h01) begin
			// Half period of 20 or more keeps it at or under the rate ceiling
			aid_cnt <= 8'h00;
			ev_pin[0] <= !ev_pin[0];
		end else begin
			aid_cnt <= aid_cnt + 8'h01;
		end
	end
endmodule // gio_host_mdl
`default_nettype wire

// File: bench/tb_gio_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_gio_top;
	logic MCLK, RESET, RESET_N_PIN, EXT_EVENT_IN_FIRST, EXT_EVENT_IN_SECOND, IFACE_SEL_PIN;
	logic BOOT_MODE_STRAP_LOW_IN, SECOND_PULSE_PIN_OUT, SECOND_PULSE_PIN_OE, TXD_PIN, SDA_PIN_OUT;
	logic SDA_PIN_OE, PSM_CYCLE_ON, BKP_WE, SYS_RESET, SPI_MODE, SERVICE_BOOT, RX_ON, WAKE;
	logic ANTENNA_AMP_ON, TIMEPULSE, AID_EDGE, rst_req, iface, tp_prev;
	logic [1:0] ev_lvl, BKP_ADDR, TIME_SYNC;
	logic [7:0] aid_half, BKP_WDATA, BKP_RDATA;
	logic [15:0] TX_QUEUE_BYTES, AID_PERIOD;
	logic [31:0] TIME_CAPT_FIRST, TIME_CAPT_SECOND, RTC_TIME, capt1;
	gio_pkg::gio_cfg_t CFG;
	gio_pkg::gio_ser_in_t SER_IN;
	gio_pkg::gio_ser_out_t SER_OUT;
	wire logic RXD_PIN = 1'h1;
	wire logic SCL_PIN = 1'h1;
	wire logic SDA_PIN_IN = !SDA_PIN_OE;
	int fails = 0, checked = 0, cycles = 0, n_ts0 = 0, n_ts1 = 0, n_wake = 0;
	int tp_hi = 0, tp_per = 0, hi_run = 0, since = 0, s0, s1, sw, n_aid = 0, sa;

	gio_top #(.TP_PERIOD_DEF(32'h28), .TP_WIDTH_DEF(32'h4)) i_dut (.*);
	gio_host_mdl i_host (.clk(MCLK), .rst_req(rst_req), .iface_uart(iface), .ev_lvl(ev_lvl),
		.aid_half(aid_half), .tp2_oe(SECOND_PULSE_PIN_OE), .tp2_out(SECOND_PULSE_PIN_OUT),
		.reset_n_pin(RESET_N_PIN), .ev_pin({EXT_EVENT_IN_SECOND, EXT_EVENT_IN_FIRST}),
		.iface_pin(IFACE_SEL_PIN), .tp2_wire(BOOT_MODE_STRAP_LOW_IN));

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic hreset;
		rst_req <= 1'h1;
		step(7);
		chk(SYS_RESET, 1'h1);
		chk(RTC_TIME, 32'h0);
		rst_req <= 1'h0;
		step(8);
	endtask
	task automatic pulse(input int ch);
		ev_lvl[ch] <= 1'h0;
		step(5);
		ev_lvl[ch] <= 1'h1;
		step(8);
	endtask

	initial begin
		MCLK = 1'h0;
		forever #25 MCLK = !MCLK;
	end
	// Counted on the falling edge so the main sequence reads settled totals
	always @(negedge MCLK) begin
		cycles++;
		n_ts0 += TIME_SYNC[0];
		n_ts1 += TIME_SYNC[1];
		n_wake += WAKE;
		n_aid += AID_EDGE;
		// Capture holds the clock time from before the edge that raised the strobe
		if (TIME_SYNC[1])
			capt1 = RTC_TIME - 32'h1;
		since++;
		if (TIMEPULSE && !tp_prev) begin
			tp_per = since;
			since = 0;
		end
		if (!TIMEPULSE && tp_prev)
			tp_hi = hi_run;
		hi_run = TIMEPULSE ? hi_run + 1 : 0;
		tp_prev = TIMEPULSE;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		RESET = 1'h1;
		rst_req = 1'h0;
		iface = 1'h1;
		ev_lvl = 2'h3;
		aid_half = 8'h00;
		CFG = '0;
		PSM_CYCLE_ON = 1'h1;
		TX_QUEUE_BYTES = 16'h5;
		SER_IN = '0;
		BKP_WE = 1'h0;
		BKP_ADDR = 2'h0;
		BKP_WDATA = 8'h00;
		tp_prev = 1'h0;
		step(3);
		RESET <= 1'h0;
		step(8);
		for (int i = 0; i < 2; i++) begin
			iface <= i[0];
			SER_IN <= {1'h0, !i[0], 1'h0};
			hreset();
			chk(SPI_MODE, !i[0]);
			chk(SERVICE_BOOT, 1'h0);
			chk(TXD_PIN, !i[0]);
			chk(i[0] ? SER_OUT.spi_cs_n : SER_OUT.ddc_sda, 1'h1);
		end
		BKP_ADDR <= 2'h2;
		BKP_WDATA <= 8'h5a;
		BKP_WE <= 1'h1;
		step(1);
		BKP_WE <= 1'h0;
		hreset();
		chk(BKP_RDATA, 8'h5a);
		step(100);
		chk(tp_per, 32'h28);
		chk(tp_hi, 32'h4);
		CFG.tp2_en <= 1'h1;
		step(4);
		chk(SECOND_PULSE_PIN_OE, 1'h1);
		CFG.tp2_en <= 1'h0;
		s0 = n_ts0;
		s1 = n_ts1;
		pulse(0);
		pulse(1);
		chk(n_ts0 - s0, 32'h0);
		chk(n_ts1 - s1, 32'h0);
		CFG.event_en <= 2'h3;
		CFG.wake_en <= 1'h1;
		CFG.psm_active <= 1'h1;
		CFG.time_aid_en <= 1'h1;
		step(2);
		s0 = n_ts0;
		s1 = n_ts1;
		sw = n_wake;
		pulse(0);
		chk(n_wake - sw, 32'h1);
		chk(n_ts0 - s0, 32'h1);
		pulse(1);
		chk(n_ts1 - s1, 32'h1);
		chk(TIME_CAPT_SECOND, capt1);
		CFG.freq_aid_en <= 1'h1;
		aid_half <= 8'h19;
		sa = n_aid;
		step(300);
		chk(AID_PERIOD, 16'h32);
		chk(n_aid - sa, 32'h5);
		aid_half <= 8'h00;
		CFG.freq_aid_en <= 1'h0;
		CFG.pwr_ctrl_en <= 1'h1;
		CFG.psm_active <= 1'h0;
		ev_lvl[0] <= 1'h0;
		step(8);
		chk(RX_ON, 1'h0);
		CFG.psm_active <= 1'h1;
		ev_lvl[0] <= 1'h1;
		step(8);
		chk(RX_ON, 1'h1);
		chk(ANTENNA_AMP_ON, 1'h1);
		ev_lvl[0] <= 1'h0;
		step(8);
		chk(RX_ON, 1'h0);
		chk(ANTENNA_AMP_ON, 1'h0);
		ev_lvl[0] <= 1'h1;
		CFG.txp_en <= 1'h1;
		CFG.txp_map <= 1'h1;
		CFG.txp_pol <= 1'h1;
		CFG.txp_thresh <= 16'h3;
		TX_QUEUE_BYTES <= 16'h2;
		step(4);
		chk(TXD_PIN, 1'h0);
		TX_QUEUE_BYTES <= 16'h3;
		step(4);
		chk(TXD_PIN, 1'h1);
		CFG.txp_pol <= 1'h0;
		step(4);
		chk(TXD_PIN, 1'h0);
		TX_QUEUE_BYTES <= 16'h0;
		step(4);
		chk(TXD_PIN, 1'h1);
		SER_IN <= 3'h1;
		CFG.tp_custom <= 1'h1;
		CFG.tp_period <= 32'h10;
		CFG.tp_width <= 32'h2;
		step(60);
		chk(SDA_PIN_OE, 1'h1);
		chk(SDA_PIN_OUT, 1'h0);
		chk(SER_OUT.ddc_sda, 1'h0);
		chk(tp_per, 32'h10);
		chk(tp_hi, 32'h2);
		give_verdict();
	end
endmodule // tb_gio_top
bind gio_top gio_top_chk i_chk (.*);
`default_nettype wire
